// ### rtl/owf_top.sv
/*
  Overlay window/frame control: row 15 control registers, user glyph RAM,
  window priority and colour, frame position counters, edge effects,
  fade/blend transition and output pin drive.
  Assumes sync inputs, pixel strobe and register writes are synchronous to
  ref_clk_i; the character generator supplies glyph dot and colour inputs.
*/
`timescale 1ns/1ps

// Summary of operation
// - Eight user glyphs of 36 bytes each, glyph n in row n, columns 0..35.
// - Each of 18 glyph lines is two bytes with four unused filler bits.
// - Border mode edges all four sides; shadow mode only right and bottom.
// - Overlapping windows: window 1 wins, down to window 4 lowest.
// - A window whose start exceeds its end is disabled.
// - Each window uses three row-15 bytes: row span, column start, end+colour.
// - Window shows only with its enable bit; separate bit enables its shadow.
// - Window fill colour is the 3-bit RGB in its third byte.
// - Vertical start: 256 steps of 4 lines, resets to 4.
// - Horizontal start: 256 steps of 6 dots, resets to 15.
// - Character height 18..127 lines; small values add 18, value 2 gives 20.
// - Pixels per line equal resolution value times 12; resets to 40.
// - Row spacing adds 0..31 blank lines under each row; resets to 0.
// - Overlay runs while overlay enable is 1 and on through any fade-out; resets to 0.
// - Edge enable turns edging on; select bit picks shadow or border.
// - Transition enable gives about 0.5 s fade or blend on overlay toggle.
// - Window clear drops all window enables; screen clear pulses screen_clear_o once.
// - Blank config 0: blank high on chars or windows; 1: chars only.
// - Overlay off: colour and blank outputs low if idle drive, else released.
// - Glyph size bit picks 12x18 or 12x16; sync polarity bits per sync.
module owf_top #(
  parameter int TRANS_CYCLES = owf_pkg::TRANS_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic glyph_sel_i,
  input wire logic [4:0] wr_row_i,
  input wire logic [5:0] wr_col_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [2:0] glyph_rd_idx_i,
  input wire logic [5:0] glyph_rd_col_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic pixel_stb_i,
  input wire logic char_dot_i,
  input wire logic char_dot_right_i,
  input wire logic char_dot_below_i,
  input wire logic char_dot_left_i,
  input wire logic char_dot_above_i,
  input wire logic [2:0] char_rgb_i,
  output logic [7:0] rd_data_o,
  output logic [7:0] glyph_rd_data_o,
  output logic [2:0] rgb_out_o,
  output logic [2:0] rgb_oe_o,
  output logic fast_blank_out_o,
  output logic fast_blank_oe_o,
  output logic screen_clear_o,
  output logic glyph_size_select_o,
  output logic [1:0] vco_band_o,
  output logic sync_collision_detect_o,
  output logic [6:0] eff_char_height_o,
  output logic [10:0] pixels_per_line_o,
  output logic [3:0] trans_level_o
);
  // a ramp shorter than its step count would leave some levels zero cycles long
  if (TRANS_CYCLES < owf_pkg::TRANS_STEPS) begin : g_bad_trans
    $error("TRANS_CYCLES too small");
  end

  // ---------------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------------
  logic [7:0] win_reg [0:11];
  logic [7:0] vert_start_reg, horz_start_reg, char_height_reg, line_res_reg;
  logic [7:0] row_spacing_reg, ovl_ctrl_reg, sync_cfg_reg;
  logic [7:0] glyph_mem [0:owf_pkg::GLYPHS*owf_pkg::GLYPH_BYTES-1];

  wire ctrl_wr = wr_en_i && !glyph_sel_i && (wr_row_i == owf_pkg::ROW_CTRL);
  wire glyph_wr = wr_en_i && glyph_sel_i && (wr_row_i[4:3] == 2'b00) &&
    (wr_col_i < 6'(owf_pkg::GLYPH_BYTES));
  wire ovl_wr = ctrl_wr && (wr_col_i[4:0] == owf_pkg::COL_OVL_CTRL) && !wr_col_i[5];
  wire win_clear = ovl_wr && wr_data_i[owf_pkg::WIN_CLR_BIT];

  // glyph n lives at n*36 + column; each dot line is two bytes
  function automatic logic [8:0] glyph_addr(input logic [2:0] g, input logic [5:0] c);
    glyph_addr = 9'(g) * 9'(owf_pkg::GLYPH_BYTES) + 9'(c);
  endfunction : glyph_addr

  always_ff @(posedge ref_clk_i) begin
    if (glyph_wr) begin
      glyph_mem[glyph_addr(wr_row_i[2:0], wr_col_i)] <= wr_data_i;
    end
    glyph_rd_data_o <= glyph_mem[glyph_addr(glyph_rd_idx_i, glyph_rd_col_i)];
  end

  // window bytes; a window clear drops only the enable bits
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < 12; i++) begin
      if (!rst_b_i) begin
        win_reg[i] <= owf_pkg::RST_ZERO;
      end else if (ctrl_wr && !wr_col_i[5] && wr_col_i[4:0] == 5'(i)) begin
        win_reg[i] <= wr_data_i;
      end else if (win_clear && (i % 3) == 1) begin
        win_reg[i][owf_pkg::WIN_EN_BIT] <= 1'b0;
      end
    end
  end

  // frame registers; clear bits self-return so they fire once
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      vert_start_reg <= owf_pkg::RST_VERT_START;
      horz_start_reg <= owf_pkg::RST_HORZ_START;
      char_height_reg <= owf_pkg::RST_ZERO;
      line_res_reg <= owf_pkg::RST_LINE_RES;
      row_spacing_reg <= owf_pkg::RST_ZERO;
      ovl_ctrl_reg <= owf_pkg::RST_ZERO;
      sync_cfg_reg <= owf_pkg::RST_ZERO;
    end else begin
      ovl_ctrl_reg[owf_pkg::WIN_CLR_BIT] <= 1'b0;
      ovl_ctrl_reg[owf_pkg::SCR_CLR_BIT] <= 1'b0;
      if (ctrl_wr && !wr_col_i[5]) begin
        case (wr_col_i[4:0])
          owf_pkg::COL_VERT_START: vert_start_reg <= wr_data_i;
          owf_pkg::COL_HORZ_START: horz_start_reg <= wr_data_i;
          owf_pkg::COL_CHAR_HEIGHT: char_height_reg <= {1'b0, wr_data_i[6:0]};
          owf_pkg::COL_LINE_RES: line_res_reg <= {1'b0, wr_data_i[6:0]};
          owf_pkg::COL_ROW_SPACING: row_spacing_reg <= {3'b000, wr_data_i[4:0]};
          owf_pkg::COL_OVL_CTRL: ovl_ctrl_reg <= wr_data_i;
          owf_pkg::COL_SYNC_CFG: sync_cfg_reg <= {wr_data_i[7:6], 1'b0, wr_data_i[4:0]};
          default: ;
        endcase
      end
    end
  end

  // readback of row 15; unmapped columns read zero
  logic [7:0] rd_next;
  always_comb begin
    rd_next = 8'h00;
    if (!wr_col_i[5] && wr_col_i[4:0] < 5'h0C) rd_next = win_reg[wr_col_i[3:0]];
    else if (!wr_col_i[5]) begin
      case (wr_col_i[4:0])
        owf_pkg::COL_VERT_START: rd_next = vert_start_reg;
        owf_pkg::COL_HORZ_START: rd_next = horz_start_reg;
        owf_pkg::COL_CHAR_HEIGHT: rd_next = char_height_reg;
        owf_pkg::COL_LINE_RES: rd_next = line_res_reg;
        owf_pkg::COL_ROW_SPACING: rd_next = row_spacing_reg;
        owf_pkg::COL_OVL_CTRL: rd_next = ovl_ctrl_reg;
        owf_pkg::COL_SYNC_CFG: rd_next = sync_cfg_reg;
        default: rd_next = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // derived geometry
  // ---------------------------------------------------------------------
  wire ovl_en = ovl_ctrl_reg[owf_pkg::OVL_EN_BIT];
  // values under 18 are offset by 18, so 2 gives 20
  wire [6:0] height_next = (char_height_reg[6:0] < owf_pkg::MIN_CHAR_HEIGHT) ?
    7'(char_height_reg[6:0] + owf_pkg::MIN_CHAR_HEIGHT) : char_height_reg[6:0];
  wire [10:0] ppl_next = 11'(line_res_reg) * owf_pkg::DOTS_PER_RES;
  wire [9:0] vstart_lines = 10'(vert_start_reg) * owf_pkg::LINES_PER_VSTEP;
  wire [10:0] hstart_dots = 11'(horz_start_reg) * owf_pkg::DOTS_PER_HSTEP;
  wire [6:0] row_pitch = 7'(height_next + 7'(row_spacing_reg[4:0]));
  // sync seen in the programmed polarity
  wire hs_act = hsync_i ~^ sync_cfg_reg[owf_pkg::HSYNC_POL_BIT];
  wire vs_act = vsync_i ~^ sync_cfg_reg[owf_pkg::VSYNC_POL_BIT];

  // ---------------------------------------------------------------------
  // raster position: dot and line counters relative to frame start
  // ---------------------------------------------------------------------
  logic hs_d_reg, vs_d_reg;
  logic [10:0] dot_reg;
  logic [9:0] line_reg;
  logic [6:0] row_line_reg;
  logic [3:0] row_reg;
  logic [3:0] col_dot_reg;
  logic [4:0] col_reg;
  wire hs_rise = hs_act && !hs_d_reg;
  wire vs_rise = vs_act && !vs_d_reg;
  wire h_in = dot_reg >= hstart_dots;
  wire v_in = line_reg >= vstart_lines;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      hs_d_reg <= 1'b0;
      vs_d_reg <= 1'b0;
      dot_reg <= 11'h000;
      line_reg <= 10'h000;
      row_line_reg <= 7'h00;
      row_reg <= 4'h0;
      col_dot_reg <= 4'h0;
      col_reg <= 5'h00;
    end else begin
      hs_d_reg <= hs_act;
      vs_d_reg <= vs_act;
      if (vs_rise) begin
        line_reg <= 10'h000;
        row_line_reg <= 7'h00;
        row_reg <= 4'h0;
      end else if (hs_rise) begin
        line_reg <= 10'(line_reg + 10'h001);
        dot_reg <= 11'h000;
        col_dot_reg <= 4'h0;
        col_reg <= 5'h00;
        if (v_in) begin
          // each row spans the glyph height plus the spacing lines
          if (row_line_reg + 7'h01 >= row_pitch) begin
            row_line_reg <= 7'h00;
            row_reg <= 4'(row_reg + 4'h1);
          end else row_line_reg <= 7'(row_line_reg + 7'h01);
        end
      end else if (pixel_stb_i && dot_reg < ppl_next) begin
        dot_reg <= 11'(dot_reg + 11'h001);
        if (h_in) begin
          if (col_dot_reg == 4'(owf_pkg::DOTS_PER_COL - 11'h001)) begin
            col_dot_reg <= 4'h0;
            col_reg <= 5'(col_reg + 5'h01);
          end else col_dot_reg <= 4'(col_dot_reg + 4'h1);
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // windows: hit test, priority, shadow
  // ---------------------------------------------------------------------
  logic [3:0] win_hit, win_shd_hit;
  logic [2:0] win_rgb [0:3];
  always_comb begin
    for (int w = 0; w < 4; w++) begin
      logic [3:0] rs, re;
      logic [4:0] cs, ce;
      logic valid;
      rs = win_reg[3*w][7:4];
      re = win_reg[3*w][3:0];
      cs = {1'b0, win_reg[3*w+1][7:4]};
      ce = win_reg[3*w+2][7:3];
      // start beyond end disables the window
      valid = (rs <= re) && (cs <= ce) && win_reg[3*w+1][owf_pkg::WIN_EN_BIT];
      win_hit[w] = valid && h_in && v_in && row_reg >= rs && row_reg <= re &&
        col_reg >= cs && col_reg <= ce;
      // shadow falls one cell right and below the window
      win_shd_hit[w] = valid && win_reg[3*w+1][owf_pkg::WIN_SHD_BIT] && h_in && v_in &&
        !win_hit[w] && row_reg >= rs && row_reg <= 4'(re + 4'h1) &&
        col_reg >= cs && col_reg <= 5'(ce + 5'h01);
      win_rgb[w] = win_reg[3*w+2][2:0];
    end
  end

  // lowest-numbered window wins where they overlap
  logic [2:0] win_color;
  logic win_any;
  always_comb begin
    win_color = 3'b000;
    win_any = 1'b0;
    for (int w = 3; w >= 0; w--) begin
      if (win_shd_hit[w]) begin
        win_color = 3'b000;
        win_any = 1'b1;
      end
      if (win_hit[w]) begin
        win_color = win_rgb[w];
        win_any = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // edge effect and pixel mux
  // ---------------------------------------------------------------------
  wire edge_on = ovl_ctrl_reg[owf_pkg::EDGE_EN_BIT];
  wire shadow_mode = ovl_ctrl_reg[owf_pkg::EDGE_SHADOW_BIT];
  // border rings all sides; shadow keeps right and bottom only
  wire edge_dot = edge_on && !char_dot_i &&
    (shadow_mode ? (char_dot_right_i || char_dot_below_i) :
     (char_dot_right_i || char_dot_below_i || char_dot_left_i || char_dot_above_i));
  wire char_px = h_in && v_in && (char_dot_i || edge_dot);
  wire [2:0] px_rgb = char_dot_i ? char_rgb_i : (edge_dot ? 3'b000 : win_color);
  // blank on chars and windows, or chars only
  wire blank_next = ovl_ctrl_reg[owf_pkg::BLANK_CFG_BIT] ? char_px : (char_px || win_any);

  // ---------------------------------------------------------------------
  // fade/blend: ramp a level over about half a second on overlay toggle
  // ---------------------------------------------------------------------
  localparam int STEP_CYC = TRANS_CYCLES / owf_pkg::TRANS_STEPS;
  logic ovl_en_d_reg;
  logic [3:0] level_reg;
  logic [31:0] step_cnt_reg;
  wire trans_en = ovl_ctrl_reg[owf_pkg::TRANS_EN_BIT];
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ovl_en_d_reg <= 1'b0;
      level_reg <= 4'h0;
      step_cnt_reg <= 32'h0000_0000;
    end else begin
      ovl_en_d_reg <= ovl_en;
      if (!trans_en) level_reg <= ovl_en ? 4'hF : 4'h0;
      else if (step_cnt_reg == 32'(STEP_CYC - 1)) begin
        step_cnt_reg <= 32'h0000_0000;
        if (ovl_en && level_reg != 4'hF) level_reg <= 4'(level_reg + 4'h1);
        else if (!ovl_en && level_reg != 4'h0) level_reg <= 4'(level_reg - 4'h1);
      end else step_cnt_reg <= 32'(step_cnt_reg + 32'h1);
    end
  end
  // blend gates colour by a dither threshold; fade gates blanking too
  wire blend = ovl_ctrl_reg[owf_pkg::TRANS_BLEND_BIT];
  wire show = (level_reg == 4'hF) || (level_reg > (col_dot_reg ^ dot_reg[3:0]));
  wire active = ovl_en || level_reg != 4'h0;

  // ---------------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------------
  wire idle_drive = sync_cfg_reg[owf_pkg::IDLE_DRIVE_BIT];
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 8'h00;
      rgb_out_o <= 3'b000;
      rgb_oe_o <= 3'b000;
      fast_blank_out_o <= 1'b0;
      fast_blank_oe_o <= 1'b0;
      screen_clear_o <= 1'b0;
      glyph_size_select_o <= 1'b0;
      vco_band_o <= 2'b00;
      sync_collision_detect_o <= 1'b0;
      eff_char_height_o <= owf_pkg::MIN_CHAR_HEIGHT;
      pixels_per_line_o <= 11'(owf_pkg::RST_LINE_RES) * owf_pkg::DOTS_PER_RES;
      trans_level_o <= 4'h0;
    end else begin
      rd_data_o <= rd_next;
      screen_clear_o <= ovl_wr && wr_data_i[owf_pkg::SCR_CLR_BIT];
      glyph_size_select_o <= sync_cfg_reg[owf_pkg::GLYPH_SIZE_BIT];
      vco_band_o <= sync_cfg_reg[1:0];
      sync_collision_detect_o <= sync_cfg_reg[4];
      eff_char_height_o <= height_next;
      pixels_per_line_o <= ppl_next;
      trans_level_o <= level_reg;
      if (active) begin
        rgb_out_o <= (show || !blend) && show ? px_rgb : 3'b000;
        fast_blank_out_o <= blank_next && (blend || show);
        rgb_oe_o <= 3'b111;
        fast_blank_oe_o <= 1'b1;
      end else begin
        // overlay off: drive low or release the pins
        rgb_out_o <= 3'b000;
        fast_blank_out_o <= 1'b0;
        rgb_oe_o <= {3{idle_drive}};
        fast_blank_oe_o <= idle_drive;
      end
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  AST_OFF_IDLE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !active && !$past(active) |=> fast_blank_oe_o == $past(idle_drive) && rgb_out_o == 3'b000)
    else $error("idle outputs wrong");
  AST_HEIGHT_MIN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ##1 eff_char_height_o >= 7'h12) else $error("char height below 18");
  AST_PPL: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ##1 pixels_per_line_o == 11'($past(line_res_reg)) * 11'h00C)
    else $error("pixels per line wrong");
  AST_CLR_SELF: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ovl_wr && wr_data_i[2] |=> ##1 !ovl_ctrl_reg[2]) else $error("clear bit stuck");
  AST_WIN_CLR: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    win_clear |=> !win_reg[1][3] && !win_reg[4][3] && !win_reg[7][3] && !win_reg[10][3])
    else $error("window enable not cleared");
  AST_SCR_CLR: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ovl_wr && wr_data_i[1] |=> screen_clear_o) else $error("screen clear not issued");
  AST_PRIO: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    win_hit[0] |-> win_color == win_reg[2][2:0]) else $error("window 1 lost priority");
  AST_DISABLED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    win_reg[0][7:4] > win_reg[0][3:0] |-> !win_hit[0]) else $error("inverted window shown");
  AST_BLANK_CHARS: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ovl_ctrl_reg[0] && !char_px |-> !blank_next) else $error("blank on window");
  AST_BORDER_ALL: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    edge_on && !shadow_mode && !char_dot_i && (char_dot_left_i || char_dot_above_i) |-> edge_dot)
    else $error("border side missing");
  AST_SHADOW_TWO: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    edge_on && shadow_mode && !char_dot_right_i && !char_dot_below_i |-> !edge_dot)
    else $error("shadow on wrong side");
endmodule : owf_top

// ### rtl/owf_pkg.sv
/*
  Package for the overlay window and frame control block: row 15 register
  indices, field positions, reset values and timing constants.
  Assumes a single 100 MHz clock domain and the serial front end decoding
  row/column addresses into a byte-wide write/read port.
*/
package owf_pkg;
  // ---------------------------------------------------------------------
  // register indices within row 15
  // ---------------------------------------------------------------------
  localparam logic [4:0] COL_WIN_BASE = 5'h00;
  localparam logic [4:0] COL_VERT_START = 5'h0C;
  localparam logic [4:0] COL_HORZ_START = 5'h0D;
  localparam logic [4:0] COL_CHAR_HEIGHT = 5'h0E;
  localparam logic [4:0] COL_LINE_RES = 5'h0F;
  localparam logic [4:0] COL_ROW_SPACING = 5'h10;
  localparam logic [4:0] COL_OVL_CTRL = 5'h11;
  localparam logic [4:0] COL_SYNC_CFG = 5'h12;
  localparam logic [4:0] ROW_CTRL = 5'h0F;
  localparam logic [4:0] NUM_WINDOWS = 5'h04;
  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int WIN_EN_BIT = 3;
  localparam int WIN_SHD_BIT = 1;
  localparam int OVL_EN_BIT = 7;
  localparam int EDGE_EN_BIT = 6;
  localparam int EDGE_SHADOW_BIT = 5;
  localparam int TRANS_EN_BIT = 4;
  localparam int TRANS_BLEND_BIT = 3;
  localparam int WIN_CLR_BIT = 2;
  localparam int SCR_CLR_BIT = 1;
  localparam int BLANK_CFG_BIT = 0;
  localparam int IDLE_DRIVE_BIT = 7;
  localparam int GLYPH_SIZE_BIT = 6;
  localparam int HSYNC_POL_BIT = 3;
  localparam int VSYNC_POL_BIT = 2;
  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_VERT_START = 8'h04;
  localparam logic [7:0] RST_HORZ_START = 8'h0F;
  localparam logic [7:0] RST_LINE_RES = 8'h28;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // ---------------------------------------------------------------------
  // geometry and timing
  // ---------------------------------------------------------------------
  localparam logic [6:0] MIN_CHAR_HEIGHT = 7'h12;
  localparam logic [9:0] LINES_PER_VSTEP = 10'h004;
  localparam logic [10:0] DOTS_PER_HSTEP = 11'h006;
  localparam logic [10:0] DOTS_PER_RES = 11'h00C;
  localparam logic [10:0] DOTS_PER_COL = 11'h00C;
  localparam int GLYPHS = 8;
  localparam int GLYPH_BYTES = 36;
  localparam int CLK_MHZ = 100;
  localparam int TRANS_TIME_MS = 500;
  localparam int TRANS_CYCLES = TRANS_TIME_MS * 1000 * CLK_MHZ;
  localparam int TRANS_STEPS = 16;
endpackage : owf_pkg

// ### tb/owf_host.sv
/*
  Host controller model: writes bytes into the control row and glyph
  memory, one byte per strobe, and sets the readback column.
  Assumes the bench calls put and look at a falling clock edge.
*/
`timescale 1ns/1ps
module owf_host #(
  parameter int PLL_WAIT = 8
) (
  input wire logic ref_clk_i,
  output logic wr_en_o,
  output logic glyph_sel_o,
  output logic [4:0] wr_row_o,
  output logic [5:0] wr_col_o,
  output logic [7:0] wr_data_o
);
  logic pll_busy;
  initial begin
    {wr_en_o, glyph_sel_o, wr_row_o, wr_col_o, wr_data_o} = '0;
    pll_busy = 1'b0;
  end
  // -------------------------------------------------------------------
  // write one byte; other places wait until the pixel loop has settled
  // -------------------------------------------------------------------
  task automatic put(input logic g, input logic [4:0] r, input logic [5:0] c,
                     input logic [7:0] d);
    if (pll_busy && !(!g && r == 5'h0F && (c == 6'h0F || c == 6'h11 || c == 6'h12))) begin
      repeat (PLL_WAIT) @(negedge ref_clk_i);
      pll_busy = 1'b0;
    end
    @(negedge ref_clk_i);
    {wr_en_o, glyph_sel_o, wr_row_o, wr_col_o, wr_data_o} = {1'b1, g, r, c, d};
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    wr_en_o = 1'b0;
    wr_data_o = ~d; // released data must not look like the last byte
    // resolution or band change unsettles the loop
    if (!g && r == 5'h0F && (c == 6'h0F || c == 6'h12)) pll_busy = 1'b1;
  endtask : put
  task automatic look(input logic [5:0] c);
    wr_col_o = c;
  endtask : look
endmodule : owf_host

// ### tb/owf_top_test.sv
/*
  Self-checking bench for the overlay window and frame control block.
  Assumes the host model in owf_host.sv; checks against an integer model.
*/
`timescale 1ns/1ps
module owf_top_test;
  logic ref_clk_i, rst_b_i, wr_en_i, glyph_sel_i, hsync_i, vsync_i, pixel_stb_i;
  logic char_dot_i, char_dot_right_i, char_dot_below_i, glyph_size_select_o;
  logic char_dot_left_i, char_dot_above_i;
  logic [4:0] wr_row_i;
  logic [5:0] wr_col_i, glyph_rd_col_i;
  logic [7:0] wr_data_i, rd_data_o, glyph_rd_data_o, gd;
  logic [2:0] glyph_rd_idx_i, char_rgb_i, rgb_out_o, rgb_oe_o;
  logic fast_blank_out_o, fast_blank_oe_o, screen_clear_o, sync_collision_detect_o;
  logic [1:0] vco_band_o;
  logic [6:0] eff_char_height_o;
  logic [10:0] pixels_per_line_o;
  logic [3:0] trans_level_o;
  logic [31:0] seed = 32'h0000918B;
  int n_errors = 0, checked = 0, m[0:18], gm[0:7], n;
  owf_host host (.ref_clk_i(ref_clk_i), .wr_en_o(wr_en_i), .glyph_sel_o(glyph_sel_i),
    .wr_row_o(wr_row_i), .wr_col_o(wr_col_i), .wr_data_o(wr_data_i));
  owf_top #(.TRANS_CYCLES(64)) uut (.ref_clk_i, .rst_b_i, .wr_en_i, .glyph_sel_i,
    .wr_row_i, .wr_col_i, .wr_data_i, .glyph_rd_idx_i, .glyph_rd_col_i, .hsync_i,
    .vsync_i, .pixel_stb_i, .char_dot_i, .char_dot_right_i, .char_dot_below_i,
    .char_dot_left_i, .char_dot_above_i,
    .char_rgb_i, .rd_data_o, .glyph_rd_data_o, .rgb_out_o, .rgb_oe_o, .fast_blank_out_o,
    .fast_blank_oe_o, .screen_clear_o, .glyph_size_select_o, .vco_band_o,
    .sync_collision_detect_o, .eff_char_height_o, .pixels_per_line_o, .trans_level_o);
  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // control write plus model update; clear bits never stay set
  task wr(input int c, input logic [7:0] d);
    host.put(1'b0, 5'h0F, 6'(c), d);
    m[c] = d & (c == 16 ? 8'h1F : c == 18 ? 8'hDF : (c == 14 || c == 15) ? 8'h7F : 8'hFF);
    if (c == 17 && d[2]) for (int k = 0; k < 4; k++) m[3 * k + 1] &= 8'hF7;
    if (c == 17) m[17] &= 8'hF9;
  endtask : wr
  task rd(input int c);
    host.look(6'(c));
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk($sformatf("col%0d", c), (c < 19) ? m[c] : 0, rd_data_o);
  endtask : rd
  task derived();
    repeat (2) @(negedge ref_clk_i);
    chk("height", (m[14] < 18) ? m[14] + 18 : m[14], eff_char_height_o);
    chk("pixels", m[15] * 12, pixels_per_line_o);
  endtask : derived
  task test_done();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // ---------------------------------------------------------------------
  // clock, random sync and dot traffic, watchdog
  // ---------------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(negedge ref_clk_i) begin
    gd = xs();
    {hsync_i, vsync_i, pixel_stb_i, char_dot_i, char_dot_right_i} <= gd[4:0];
    {char_dot_below_i, char_dot_left_i, char_dot_above_i} <= gd[7:5];
    char_rgb_i <= seed[10:8];
  end
  initial begin
    #500000;
    n_errors++;
    test_done();
  end
  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    {rst_b_i, glyph_rd_idx_i, glyph_rd_col_i} = '0;
    {hsync_i, vsync_i, pixel_stb_i, char_dot_i, char_dot_right_i} = '0;
    {char_dot_below_i, char_dot_left_i, char_dot_above_i, char_rgb_i} = '0;
    foreach (m[i]) m[i] = 0;
    m[12] = 4;
    m[13] = 15;
    m[15] = 40;
    repeat (4) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    for (int c = 0; c < 21; c++) rd(c);
    derived();
    $display("reset values done");
    wr(14, 8'h02);
    derived();
    repeat (6) begin
      wr(12, xs());
      wr(13, xs());
      wr(14, xs() % 72);
      wr(15, 36 + xs() % 92);
      wr(16, xs());
      for (int c = 12; c < 17; c++) rd(c);
      derived();
    end
    $display("frame fields done");
    wr(17, 8'h86);
    n = 0;
    repeat (3) begin
      if (screen_clear_o === 1'b1) n++;
      @(negedge ref_clk_i);
    end
    chk("clear pulses", 1, n);
    rd(17);
    for (int k = 0; k < 4; k++) wr(3 * k + 1, xs() | 8'h08);
    wr(17, 8'h04);
    for (int k = 0; k < 12; k++) rd(k);
    rd(17);
    $display("clear bits done");
    wr(17, 8'h00);
    wr(18, 8'hFF);
    rd(18);
    repeat (2) @(negedge ref_clk_i);
    chk("band", 3, vco_band_o);
    chk("glyph size", 1, glyph_size_select_o);
    chk("collision", 1, sync_collision_detect_o);
    chk("rgb oe", 7, rgb_oe_o);
    chk("blank oe", 1, fast_blank_oe_o);
    chk("rgb", 0, {rgb_out_o, fast_blank_out_o});
    wr(18, 8'h00);
    repeat (2) @(negedge ref_clk_i);
    chk("idle release", 0, {rgb_oe_o, fast_blank_oe_o});
    $display("pin drive done");
    wr(17, 8'hD0);
    repeat (2) @(negedge ref_clk_i);
    chk("ramp start", 1, trans_level_o < 4'hF);
    repeat (80) @(negedge ref_clk_i);
    chk("ramp up", 15, trans_level_o);
    chk("rgb oe on", 7, rgb_oe_o);
    wr(17, 8'h70);
    repeat (80) @(negedge ref_clk_i);
    chk("ramp down", 0, trans_level_o);
    chk("off release", 0, {rgb_oe_o, fast_blank_oe_o, fast_blank_out_o});
    $display("transition done");
    for (int r = 0; r < 8; r++) begin
      gm[r] = xs() & 8'hFF;
      host.put(1'b1, 5'(r), 6'(35 - 5 * r), 8'(gm[r]));
    end
    for (int r = 0; r < 8; r++) begin
      glyph_rd_idx_i = 3'(r);
      glyph_rd_col_i = 6'(35 - 5 * r);
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk("glyph", gm[r], glyph_rd_data_o);
    end
    $display("glyph memory done");
    test_done();
  end
endmodule : owf_top_test
